// File: tlbtp_cfg.svh
// Offsets, field positions and reset values for the translation buffer.
`ifndef TLBTP_CFG_SVH
`define TLBTP_CFG_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TLBTP_CTRL_OFF 12'h000
`define TLBTP_MSTATE_OFF 12'h004
`define TLBTP_PID_OFF 12'h008
`define TLBTP_SEL_OFF 12'h00c
`define TLBTP_ENT0_OFF 12'h010
`define TLBTP_ENT1_OFF 12'h014
`define TLBTP_ENT2_OFF 12'h018
`define TLBTP_INVA_OFF 12'h01c
`define TLBTP_STAT_OFF 12'h020
// ----------------------------------------------------------------------
// Control bits (write one, self clearing)
// ----------------------------------------------------------------------
`define TLBTP_CTRL_FLASH 0
`define TLBTP_CTRL_WRITE 1
`define TLBTP_CTRL_INVAL 2
`define TLBTP_CTRL_PURGE 3
// ----------------------------------------------------------------------
// Machine state bits
// ----------------------------------------------------------------------
`define TLBTP_MS_ISPACE 0
`define TLBTP_MS_DSPACE 1
`define TLBTP_MS_USER 2
`define TLBTP_MSTATE_RST 3'h0
// ----------------------------------------------------------------------
// Page size codes and geometry
// ----------------------------------------------------------------------
`define TLBTP_SIZE_MIN 4'h1
`define TLBTP_SIZE_MAX 4'h9
`define TLBTP_PAGE_BITS 12
`define TLBTP_EPN_ONES 20'hfffff
`endif

// File: tlbtp_pkg.sv
// Types shared by the translation buffer and its users.
package tlbtp_pkg;
  // One translation entry; perm is {ux, sx, uw, sw, ur, sr}.
  typedef struct packed {
    logic valid;
    logic ts;
    logic [7:0] translation_id;
    logic [19:0] effective_page_num;
    logic [19:0] real_page_num;
    logic [3:0] size;
    logic [5:0] perm;
    logic [4:0] mem_attr_bits;
    logic [3:0] usr;
    logic inval_protect;
    logic var_length_page_flag;
  } tlbtp_entry_t;

  // Attributes presented with a translated address.
  typedef struct packed {
    logic [4:0] mem_attr_bits;
    logic [3:0] usr;
    logic inval_protect;
    logic var_length_page_flag;
  } tlbtp_attr_t;

  // Result of one lookup.
  typedef struct packed {
    logic done;
    logic hit;
    logic miss;
    logic fault;
    logic [31:0] ra;
    tlbtp_attr_t attr;
  } tlbtp_resp_t;
endpackage

// File: tlbtp_top.sv
// Sixteen-entry fully associative translation buffer with APB access.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "tlbtp_cfg.svh"
module tlbtp_top #(
  parameter int ENTRIES = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Instruction fetch lookup
  input wire logic fetch_req_in,
  input wire logic [31:0] fetch_ea_in,
  output tlbtp_pkg::tlbtp_resp_t fetch_resp_out,
  // Load/store lookup
  input wire logic data_req_in,
  input wire logic data_store_in,
  input wire logic [31:0] data_ea_in,
  output tlbtp_pkg::tlbtp_resp_t data_resp_out
);
  import tlbtp_pkg::*;

  localparam int IW = $clog2(ENTRIES);

  // --------------------------------------------------------------------
  // Storage and software-visible state
  // --------------------------------------------------------------------
  tlbtp_entry_t ent_q [ENTRIES];
  logic [2:0] mstate_q;
  logic [7:0] pid_q;
  logic [IW-1:0] esel_q;
  logic [IW-1:0] nvic_q;
  logic [31:0] stage0_q;
  logic [31:0] stage1_q;
  logic [31:0] stage2_q;
  logic [19:0] inva_q;
  logic [8:0] stat_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  tlbtp_resp_t fresp_q;
  tlbtp_resp_t dresp_q;

  // Page mask: low bits of the page number ignored for larger pages.
  function automatic logic [19:0] page_mask(input logic [3:0] size);
    logic [4:0] sh;
    sh = 5'(2 * (size - 4'h1));
    return 20'(`TLBTP_EPN_ONES << sh);
  endfunction

  // Full match of one entry against a page number, space and id.
  function automatic logic ent_match(input tlbtp_entry_t e,
                                     input logic [19:0] pg,
                                     input logic as_bit,
                                     input logic [7:0] pid);
    logic legal;
    legal = (e.size >= `TLBTP_SIZE_MIN) && (e.size <= `TLBTP_SIZE_MAX);
    return e.valid && legal
      && (e.ts == as_bit)
      && ((e.translation_id == 8'h00) || (e.translation_id == pid))
      && (((e.effective_page_num ^ pg) & page_mask(e.size)) == 20'h00000);
  endfunction

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  logic apb_setup;
  logic apb_done;
  logic wr_ctrl;
  logic known;
  assign apb_setup = psel_in && !penable_in;
  assign apb_done = psel_in && penable_in && pready_q;
  assign wr_ctrl = apb_done && pwrite_in && !pslverr_q
                   && (paddr_in == `TLBTP_CTRL_OFF);

  // Address decode for the error answer; read data has its own case.
  always_comb
  begin
    case (paddr_in)
      `TLBTP_CTRL_OFF, `TLBTP_MSTATE_OFF, `TLBTP_PID_OFF,
      `TLBTP_SEL_OFF, `TLBTP_ENT0_OFF, `TLBTP_ENT1_OFF,
      `TLBTP_ENT2_OFF, `TLBTP_INVA_OFF, `TLBTP_STAT_OFF: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // No wait state: ready rises in the first access cycle, from a flop.
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !known;
    end
  end

  // Read data is captured in the setup cycle.
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      prdata_q <= 32'h00000000;
    else if (apb_setup && !pwrite_in)
    begin
      case (paddr_in)
        `TLBTP_MSTATE_OFF: prdata_q <= {29'h0, mstate_q};
        `TLBTP_PID_OFF: prdata_q <= {24'h0, pid_q};
        `TLBTP_SEL_OFF: prdata_q <= {20'h0, 4'(nvic_q), 4'h0, 4'(esel_q)};
        `TLBTP_ENT0_OFF: prdata_q <= stage0_q;
        `TLBTP_ENT1_OFF: prdata_q <= stage1_q;
        `TLBTP_ENT2_OFF: prdata_q <= stage2_q;
        `TLBTP_INVA_OFF: prdata_q <= {inva_q, 12'h000};
        `TLBTP_STAT_OFF: prdata_q <= {23'h0, stat_q};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  // Plain software registers.
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      mstate_q <= `TLBTP_MSTATE_RST;
      pid_q <= 8'h00;
      stage0_q <= 32'h00000000;
      stage1_q <= 32'h00000000;
      stage2_q <= 32'h00000000;
      inva_q <= 20'h00000;
    end
    else if (apb_done && pwrite_in)
    begin
      case (paddr_in)
        `TLBTP_MSTATE_OFF: mstate_q <= pwdata_in[2:0];
        `TLBTP_PID_OFF: pid_q <= pwdata_in[7:0];
        `TLBTP_ENT0_OFF: stage0_q <= pwdata_in;
        `TLBTP_ENT1_OFF: stage1_q <= pwdata_in;
        `TLBTP_ENT2_OFF: stage2_q <= pwdata_in;
        `TLBTP_INVA_OFF: inva_q <= pwdata_in[31:12];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Parallel lookup for both ports
  // --------------------------------------------------------------------
  logic [ENTRIES-1:0] fhit;
  logic [ENTRIES-1:0] dhit;
  logic [ENTRIES-1:0] ihit;
  tlbtp_entry_t fsel;
  tlbtp_entry_t dsel;

  // Multiple hits OR their entries together, giving a garbage result.
  always_comb
  begin
    fsel = '0;
    dsel = '0;
    for (int i = 0; i < ENTRIES; i++)
    begin
      fhit[i] = ent_match(ent_q[i], fetch_ea_in[31:12],
                          mstate_q[`TLBTP_MS_ISPACE], pid_q);
      dhit[i] = ent_match(ent_q[i], data_ea_in[31:12],
                          mstate_q[`TLBTP_MS_DSPACE], pid_q);
      ihit[i] = ent_q[i].valid && (((ent_q[i].effective_page_num ^ inva_q)
                & page_mask(ent_q[i].size)) == 20'h00000);
      if (fhit[i])
        fsel = fsel | ent_q[i];
      if (dhit[i])
        dsel = dsel | ent_q[i];
    end
  end

  logic usr;
  logic f_ok;
  logic d_ok;
  assign usr = mstate_q[`TLBTP_MS_USER];
  // Execute: perm[5] user, perm[4] supervisor.
  assign f_ok = usr ? fsel.perm[5] : fsel.perm[4];
  // Stores check write bits, loads check read bits.
  assign d_ok = data_store_in ? (usr ? dsel.perm[3] : dsel.perm[2])
                              : (usr ? dsel.perm[1] : dsel.perm[0]);

  // Build a registered answer; guarded pages need no stall.
  function automatic tlbtp_resp_t mk_resp(input logic req,
                                          input logic hit,
                                          input logic ok,
                                          input tlbtp_entry_t e,
                                          input logic [31:0] ea);
    tlbtp_resp_t r;
    logic [19:0] m;
    m = page_mask(e.size);
    r.done = req;
    r.hit = req && hit;
    r.miss = req && !hit;
    r.fault = req && hit && !ok;
    r.ra = {(e.real_page_num & m) | (ea[31:12] & ~m),
            ea[`TLBTP_PAGE_BITS-1:0]};
    r.attr = {e.mem_attr_bits, e.usr, e.inval_protect, e.var_length_page_flag};
    return r;
  endfunction

  // Lookup answers appear one cycle after the request.
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      fresp_q <= '0;
      dresp_q <= '0;
    end
    else
    begin
      fresp_q <= mk_resp(fetch_req_in, |fhit, f_ok, fsel, fetch_ea_in);
      dresp_q <= mk_resp(data_req_in, |dhit, d_ok, dsel, data_ea_in);
    end
  end

  // Sticky status of the last faults; a write of ones clears them.
  logic multi;
  logic [3:0] ev;
  assign multi = ($countones(fhit) > 1) || ($countones(dhit) > 1);
  assign ev = {data_req_in && !(|dhit), fetch_req_in && !(|fhit),
               data_req_in && (|dhit) && !d_ok,
               fetch_req_in && (|fhit) && !f_ok};
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      stat_q <= 9'h000;
    else
    begin
      stat_q[3:0] <= 4'(esel_q);
      // Set wins over a clear arriving in the same cycle.
      if (apb_done && pwrite_in && (paddr_in == `TLBTP_STAT_OFF))
        stat_q[8:4] <= (stat_q[8:4] & ~pwdata_in[8:4]) | {ev, multi};
      else
        stat_q[8:4] <= stat_q[8:4] | {ev, multi};
    end
  end

  // --------------------------------------------------------------------
  // Victim selection
  // --------------------------------------------------------------------
  logic miss_any;
  assign miss_any = ev[3] || ev[2];
  // A TLB miss on either port copies the next victim into the entry selector.
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      esel_q <= '0;
      nvic_q <= '0;
    end
    else
    begin
      if (miss_any)
        esel_q <= nvic_q;
      else if (apb_done && pwrite_in && paddr_in == `TLBTP_SEL_OFF)
        esel_q <= pwdata_in[IW-1:0];
      if (apb_done && pwrite_in && paddr_in == `TLBTP_SEL_OFF)
        nvic_q <= pwdata_in[8+IW-1:8];
    end
  end

  // --------------------------------------------------------------------
  // Entry maintenance
  // --------------------------------------------------------------------
  tlbtp_entry_t wr_ent;
  always_comb
  begin
    wr_ent.effective_page_num = stage0_q[19:0];
    wr_ent.size = stage0_q[23:20];
    wr_ent.ts = stage0_q[24];
    wr_ent.valid = stage0_q[25];
    wr_ent.inval_protect = stage0_q[26];
    wr_ent.var_length_page_flag = stage0_q[27];
    wr_ent.real_page_num = stage1_q[19:0];
    wr_ent.perm = stage1_q[25:20];
    wr_ent.translation_id = stage2_q[7:0];
    wr_ent.mem_attr_bits = stage2_q[12:8];
    wr_ent.usr = stage2_q[16:13];
  end

  // Write op ignores protection; invalidations spare protected ones.
  // Purging only unprotected entries keeps handler mappings resident.
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < ENTRIES; i++)
        ent_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        if (wr_ctrl && pwdata_in[`TLBTP_CTRL_FLASH] && !ent_q[i].inval_protect)
          ent_q[i].valid <= 1'b0;
        else if (wr_ctrl && pwdata_in[`TLBTP_CTRL_INVAL]
                 && !ent_q[i].inval_protect
                 && (pwdata_in[`TLBTP_CTRL_PURGE] || ihit[i]))
          ent_q[i].valid <= 1'b0;
        else if (wr_ctrl && pwdata_in[`TLBTP_CTRL_WRITE]
                 && (IW'(i) == esel_q))
          ent_q[i] <= wr_ent;
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign fetch_resp_out = fresp_q;
  assign data_resp_out = dresp_q;

endmodule // tlbtp_top

// File: tlbtp_top_checker.sv
// Concurrent checks on the translation buffer ports.
`timescale 1ns/100ps
module tlbtp_top_checker
  import tlbtp_pkg::*;
#(
  parameter int ENTRIES = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // APB handshake
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Lookups
  input wire logic fetch_req_in,
  input wire logic [31:0] fetch_ea_in,
  input wire tlbtp_pkg::tlbtp_resp_t fetch_resp_out,
  input wire logic data_req_in,
  input wire logic [31:0] data_ea_in,
  input wire tlbtp_pkg::tlbtp_resp_t data_resp_out
);
  // ------
  // Properties
  // ------
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  // A lookup is answered next cycle by exactly one of hit or miss.
  property p_f_ans;
    fetch_req_in |=> fetch_resp_out.done &&
      (fetch_resp_out.hit ^ fetch_resp_out.miss);
  endproperty
  a_f_ans: assert property (p_f_ans)
    else $error("fetch lookup not answered");
  property p_d_ans;
    data_req_in |=> data_resp_out.done &&
      (data_resp_out.hit ^ data_resp_out.miss);
  endproperty
  a_d_ans: assert property (p_d_ans)
    else $error("data lookup not answered");
  // Without a request data done, hit, miss and fault stay low; fetch done and fault too.
  property p_d_quiet;
    !data_req_in |=> !(data_resp_out.done || data_resp_out.hit ||
      data_resp_out.miss || data_resp_out.fault);
  endproperty
  a_d_quiet: assert property (p_d_quiet)
    else $error("data answer without request");
  property p_f_quiet;
    !fetch_req_in |=> !fetch_resp_out.done && !fetch_resp_out.fault;
  endproperty
  a_f_quiet: assert property (p_f_quiet)
    else $error("fetch answer without request");
  // A permission fault only follows a successful match.
  property p_f_flt;
    fetch_resp_out.fault |-> fetch_resp_out.hit && !fetch_resp_out.miss;
  endproperty
  a_f_flt: assert property (p_f_flt)
    else $error("fetch fault without hit");
  property p_d_flt;
    data_resp_out.fault |-> data_resp_out.hit && !data_resp_out.miss;
  endproperty
  a_d_flt: assert property (p_d_flt)
    else $error("data fault without hit");
  // The page offset passes through untranslated.
  property p_f_off;
    fetch_req_in |=> !fetch_resp_out.hit ||
      fetch_resp_out.ra[11:0] == $past(fetch_ea_in[11:0]);
  endproperty
  a_f_off: assert property (p_f_off)
    else $error("fetch offset altered");
  property p_d_off;
    data_req_in |=> !data_resp_out.hit ||
      data_resp_out.ra[11:0] == $past(data_ea_in[11:0]);
  endproperty
  a_d_off: assert property (p_d_off)
    else $error("data offset altered");
  // Ready stands for the first access cycle only.
  property p_rdy;
    psel_in && !penable_in |=> pready_out ##1 !pready_out;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready timing wrong");
  c_fault: cover property (data_resp_out.fault);
  c_fmiss: cover property (fetch_resp_out.miss);
  c_slverr: cover property (pready_out && pslverr_out);
endmodule // tlbtp_top_checker

bind tlbtp_top tlbtp_top_checker #(.ENTRIES(ENTRIES)) u_checker (
  .mclk_in, .rstn_in, .psel_in, .penable_in, .pready_out, .pslverr_out,
  .fetch_req_in, .fetch_ea_in, .fetch_resp_out, .data_req_in,
  .data_ea_in, .data_resp_out);

// File: tlbtp_core_model.sv
// Behavioural fetch and load/store units issuing lookups.
`timescale 1ns/100ps
module tlbtp_core_model
  import tlbtp_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Requests
  output logic fetch_req_out,
  output logic [31:0] fetch_ea_out,
  output logic data_req_out,
  output logic data_store_out,
  output logic [31:0] data_ea_out,
  // Answers
  input wire tlbtp_pkg::tlbtp_resp_t fetch_resp_in,
  input wire tlbtp_pkg::tlbtp_resp_t data_resp_in
);
  // Quiet at time zero.
  initial
  begin
    fetch_req_out = 1'b0;
    data_req_out = 1'b0;
    data_store_out = 1'b0;
    fetch_ea_out = 32'h0;
    data_ea_out = 32'h0;
  end
  // Kind 0 load, 1 store, 2 fetch; a one-cycle request pulse.
  // Idle addresses flip so a stale value is never mistaken for a live one.
  task automatic look(input logic [1:0] k, input logic [31:0] ea,
                      output tlbtp_resp_t r);
    @(posedge mclk_in);
    fetch_req_out <= (k == 2'd2);
    data_req_out <= (k != 2'd2);
    data_store_out <= (k == 2'd1);
    if (k == 2'd2)
      fetch_ea_out <= ea;
    else
      data_ea_out <= ea;
    @(posedge mclk_in);
    fetch_req_out <= 1'b0;
    data_req_out <= 1'b0;
    fetch_ea_out <= ~fetch_ea_out;
    data_ea_out <= ~data_ea_out;
    r = '0;
    repeat (4)
    begin
      @(posedge mclk_in);
      r = (k == 2'd2) ? fetch_resp_in : data_resp_in;
      if (r.done === 1'b1)
        break;
    end
  endtask
endmodule // tlbtp_core_model

// File: tlb_translate_permission_bench.sv
// Self-checking bench for the translation buffer and its registers.
`timescale 1ns/100ps
`include "tlbtp_cfg.svh"
module tlb_translate_permission_bench;
  import tlbtp_pkg::*;
  logic mclk_in = 0, rstn_in = 0, psel = 0, pen = 0, pwr = 0, err;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, q, fea, dea;
  logic pready, pslv, freq, dreq, dst;
  tlbtp_resp_t fr, dr, r;
  int mismatches = 0, samples_checked = 0;
  // ------
  // Harness
  // ------
  // 100 MHz clock.
  initial
  forever #5 mclk_in = ~mclk_in;
  tlbtp_top #(.ENTRIES(16)) DUT (.mclk_in, .rstn_in, .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(pready), .pslverr_out(pslv),
    .fetch_req_in(freq), .fetch_ea_in(fea), .fetch_resp_out(fr),
    .data_req_in(dreq), .data_store_in(dst), .data_ea_in(dea),
    .data_resp_out(dr));
  tlbtp_core_model u_core (.mclk_in, .fetch_req_out(freq),
    .fetch_ea_out(fea), .data_req_out(dreq), .data_store_out(dst),
    .data_ea_out(dea), .fetch_resp_in(fr), .data_resp_in(dr));
  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge mclk_in);
    pen <= 1'b1;
    // No wait count is assumed; only the watchdog ends a stuck wait.
    @(posedge mclk_in);
    while (pready !== 1'b1)
      @(posedge mclk_in);
    q = prd;
    err = pslv;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Stage an entry and write it to the selected slot.
  task automatic ent(input logic [3:0] i, input logic [31:0] w0, w1, w2);
    wr(`TLBTP_SEL_OFF, {28'h0, i});
    wr(`TLBTP_ENT0_OFF, w0);
    wr(`TLBTP_ENT1_OFF, w1);
    wr(`TLBTP_ENT2_OFF, w2);
    wr(`TLBTP_CTRL_OFF, 32'h2);
  endtask
  task automatic lk(input logic [1:0] k, input logic [31:0] ea,
                    input logic h, m, f, input logic [31:0] ra);
    u_core.look(k, ea, r);
    chk({r.done, r.hit, r.miss, r.fault, h ? r.ra : 32'h0},
        {1'b1, h, m, f, ra});
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    rd(`TLBTP_MSTATE_OFF, 32'h0);
    rd(`TLBTP_STAT_OFF, 32'h0);
    rd(12'hffc, 32'h0);
    chk(err, 1'b1);
    wr(`TLBTP_SEL_OFF, 32'h500);
    lk(2'd0, 32'h1000, 0, 1, 0, 0);
    lk(2'd2, 32'h2000, 0, 1, 0, 0);
    rd(`TLBTP_STAT_OFF, 32'h185);
    wr(`TLBTP_STAT_OFF, 32'h1f0);
    rd(`TLBTP_STAT_OFF, 32'h5);
  endtask
  // Size codes 0 to 10; legal ones inside the page and one bit past it.
  task automatic t_size();
    logic [31:0] ea, m;
    int sh;
    for (int k = 0; k <= 10; k++)
    begin
      sh = 10 + 2 * k;
      m = ~((32'h1 << sh) - 32'h1);
      ea = 32'h12345000 ^ ~m;
      ent(4'h0, {8'h02, 4'(k), 20'h12345}, 32'h03fabcde, 32'h0);
      if (k >= 1 && k <= 9)
      begin
        lk(2'd0, ea, 1, 0, 0, (32'habcde000 & m) | (ea & ~m));
        lk(2'd0, ea ^ (32'h1 << sh), 0, 1, 0, 0);
      end
      else
        lk(2'd0, ea, 0, 1, 0, 0);
    end
  endtask
  // One permission bit at a time, both modes, all three access kinds.
  task automatic t_perm();
    for (int p = 0; p < 6; p++)
    begin
      ent(4'h1, 32'h02100040, {6'h0, 6'(1 << p), 20'h50}, 32'h15500);
      for (int u = 0; u < 2; u++)
      begin
        wr(`TLBTP_MSTATE_OFF, 32'(u << 2));
        for (int a = 0; a < 3; a++)
        begin
          lk(2'(a), 32'h40abc, 1, 0, p != 2 * a + u, 32'h50abc);
          chk(r.attr, 11'h568);
        end
      end
    end
  endtask
  task automatic t_space();
    ent(4'h2, 32'h03100070, 32'h03f00080, 32'h7);
    wr(`TLBTP_PID_OFF, 32'h7);
    wr(`TLBTP_MSTATE_OFF, 32'h2);
    lk(2'd0, 32'h70000, 1, 0, 0, 32'h80000);
    lk(2'd2, 32'h70000, 0, 1, 0, 0);
    wr(`TLBTP_MSTATE_OFF, 32'h1);
    lk(2'd2, 32'h70000, 1, 0, 0, 32'h80000);
    lk(2'd0, 32'h70000, 0, 1, 0, 0);
    wr(`TLBTP_PID_OFF, 32'h3);
    lk(2'd2, 32'h70000, 0, 1, 0, 0);
    ent(4'h2, 32'h03100070, 32'h03f00080, 32'h0);
    lk(2'd2, 32'h70000, 1, 0, 0, 32'h80000);
  endtask
  // Protected entry survives flash, address and purge invalidation.
  task automatic t_inval();
    wr(`TLBTP_MSTATE_OFF, 32'h0);
    ent(4'h3, 32'h06100300, 32'h03f00300, 32'h0);
    ent(4'h4, 32'h02100400, 32'h03f00400, 32'h0);
    wr(`TLBTP_CTRL_OFF, 32'h1);
    lk(2'd0, 32'h300000, 1, 0, 0, 32'h300000);
    lk(2'd0, 32'h400000, 0, 1, 0, 0);
    ent(4'h4, 32'h02100400, 32'h03f00400, 32'h0);
    wr(`TLBTP_INVA_OFF, 32'h400000);
    wr(`TLBTP_CTRL_OFF, 32'h4);
    lk(2'd0, 32'h400123, 0, 1, 0, 0);
    ent(4'h4, 32'h02100400, 32'h03f00400, 32'h0);
    wr(`TLBTP_INVA_OFF, 32'h300000);
    wr(`TLBTP_CTRL_OFF, 32'hc);
    lk(2'd1, 32'h300000, 1, 0, 0, 32'h300000);
    lk(2'd1, 32'h400000, 0, 1, 0, 0);
    ent(4'h3, 32'h04100300, 32'h03f00300, 32'h0);
    lk(2'd0, 32'h300000, 0, 1, 0, 0);
  endtask
  // Overlapping entries, one in the last slot.
  task automatic t_multi();
    ent(4'h5, 32'h02100500, 32'h03f00500, 32'h0);
    ent(4'hf, 32'h02100500, 32'h03f00500, 32'h0);
    wr(`TLBTP_STAT_OFF, 32'h1f0);
    u_core.look(2'd0, 32'h500000, r);
    chk({r.done, r.hit, r.miss, r.ra}, {3'b110, 32'h500000});
    rd(`TLBTP_STAT_OFF, 32'h1f);
    // Selector holds the software choice, next victim stays zero.
    rd(`TLBTP_SEL_OFF, 32'h00f);
  endtask
  task automatic wrap_up();
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence after four reset cycles.
  initial
  begin
    repeat (4) @(posedge mclk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_size();
    t_perm();
    t_space();
    t_inval();
    t_multi();
    wrap_up();
  end
  // The run needs under a thousand cycles; this cuts a hang short.
  initial
  begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule // tlb_translate_permission_bench
